// ### rtc_regs.sv
// rtc_regs: power-saving, carrier-detect override, manual clock, synthesizer
// lock delay and chip identification registers.
// assumes the serial port framing lives outside and hands over single-cycle
// read and write strobes on CLK_SYS; analog and control bits come in as
// same-clock levels from their own registers.
//
// Notes on behaviour
// [R01] power-save bit seven shuts unused circuitry
// [R02] power-save writes need analog gate bit
// [R03] host sets power-save bit during init
// [R04] host writes zero to reserved low bits
// [R05] override bit seven forces carrier detect
// [R06] override writes need analog gate bit
// [R07] host loads both clock registers 0x41
// [R08] lock wait is count times 2 us
// [R09] counted wait only in auto synth mode
// [R10] identification bits 31:30 read as zero
// [R11] identification readable only with read enable
// [R12] host enables id read only briefly
// [R13] id read-only, four bytes, LSB lowest
// [R14] gated-off writes leave contents unchanged
// [R15] disabled id reads return zero
`timescale 1ns/1ps
`default_nettype none

module rtc_regs
  import rtc_pkg::*;
(
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST,
  input  wire logic                    REQ_WR,
  input  wire logic                    REQ_RD,
  input  wire logic [5:0]              REQ_ADDR,
  input  wire logic [7:0]              REQ_WDATA,
  input  wire logic [7:0]              ANALOG_CTRL,
  input  wire logic [7:0]              RADIO_CTRL,
  input  wire logic                    PLL_LOCK_USED,
  input  wire logic                    SYNTH_START,
  input  wire logic [RTC_ID_WIDTH-1:0] CHIP_ID,
  input  wire logic                    CD_RAW,
  output logic [7:0]                   RD_DATA,
  output logic                         RD_VALID,
  output logic                         POWER_SAVE,
  output logic                         CD_OUT,
  output logic [7:0]                   CLK_OVR,
  output logic [7:0]                   CLK_EN,
  output logic                         SYNTH_LOCKED
);

  // ==========================================================================
  // request decode
  rtc_req_t req;
  assign req = '{wr: REQ_WR, rd: REQ_RD, addr: REQ_ADDR, wdata: REQ_WDATA};

  wire       wr_gate   = ANALOG_CTRL[RTC_BIT_WR_GATE];
  wire       id_rd_en  = ANALOG_CTRL[RTC_BIT_ID_RD_EN];
  wire       auto_mode = ~RADIO_CTRL[RTC_BIT_AUTO_SYNTH];
  wire       wr_ps     = req.wr && req.addr == RTC_ADDR_PWR_SAVE && wr_gate;
  wire       wr_cd     = req.wr && req.addr == RTC_ADDR_CD_OVR && wr_gate;
  wire       wr_co     = req.wr && req.addr == RTC_ADDR_CLK_OVR;
  wire       wr_ce     = req.wr && req.addr == RTC_ADDR_CLK_EN;
  wire       wr_lc     = req.wr && req.addr == RTC_ADDR_LOCK_CNT;
  wire       id_hit    = req.addr[5:2] == RTC_ADDR_ID_BASE[5:2];

  logic [7:0] ps_reg, cd_reg, co_reg, ce_reg, lc_reg;

  // ==========================================================================
  // writable registers; gated writes hold contents when gate is low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ps_reg <= RTC_RST_PWR_SAVE;
      cd_reg <= RTC_RST_CD_OVR;
      co_reg <= RTC_RST_CLK_OVR;
      ce_reg <= RTC_RST_CLK_EN;
      lc_reg <= RTC_RST_LOCK_CNT;
    end else begin
      if (wr_ps) ps_reg <= req.wdata; // [R02] [R14]
      if (wr_cd) cd_reg <= req.wdata; // [R06] [R14]
      if (wr_co) co_reg <= req.wdata;
      if (wr_ce) ce_reg <= req.wdata;
      if (wr_lc) lc_reg <= req.wdata;
    end
  end

  assign POWER_SAVE = ps_reg[RTC_BIT_CTRL];                  // [R01]
  assign CD_OUT     = cd_reg[RTC_BIT_CTRL] | CD_RAW;         // [R05]
  assign CLK_OVR    = co_reg;
  assign CLK_EN     = ce_reg;

  // ==========================================================================
  // identification byte select, zero top bits, zero when disabled
  wire [31:0] id_word  = {2'b00, CHIP_ID};                   // [R10]
  wire [7:0]  id_byte  = id_rd_en ? id_word[req.addr[1:0]*8 +: 8]
                                  : 8'h00;                   // [R11] [R13] [R15]

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (id_hit) rd_mux = id_byte;
    else begin
      case (req.addr)
        RTC_ADDR_PWR_SAVE: rd_mux = ps_reg;
        RTC_ADDR_CD_OVR:   rd_mux = cd_reg;
        RTC_ADDR_CLK_OVR:  rd_mux = co_reg;
        RTC_ADDR_CLK_EN:   rd_mux = ce_reg;
        RTC_ADDR_LOCK_CNT: rd_mux = lc_reg;
        default:           rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RD_DATA  <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_DATA  <= req.rd ? rd_mux : RD_DATA;
      RD_VALID <= req.rd;
    end
  end

  // ==========================================================================
  // synthesizer lock delay: count steps of 2 us, then report lock.
  // with manual synth control or the pll lock pin in use, lock is immediate unless a counted wait is already under way.
  rtc_lock_state_t lk_reg, lk_next;
  logic [7:0]  step_reg;
  logic [15:0] cyc_reg;
  wire counted   = auto_mode && !PLL_LOCK_USED;              // [R09]
  wire step_tick = cyc_reg == 16'(RTC_LOCK_STEP_CYC - 1);

  always_comb begin
    lk_next = lk_reg;
    case (lk_reg)
      RTC_LK_IDLE: if (SYNTH_START) lk_next = counted && lc_reg != 8'h00
                                              ? RTC_LK_WAIT : RTC_LK_DONE;
      RTC_LK_WAIT: if (step_tick && step_reg == 8'h01) lk_next = RTC_LK_DONE;
      RTC_LK_DONE: if (SYNTH_START) lk_next = counted && lc_reg != 8'h00
                                              ? RTC_LK_WAIT : RTC_LK_DONE;
      default:     lk_next = RTC_LK_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lk_reg   <= RTC_LK_IDLE;
      step_reg <= 8'h00;
      cyc_reg  <= 16'h0000;
    end else begin
      lk_reg <= lk_next;
      if (SYNTH_START) begin
        step_reg <= lc_reg;                                  // [R08]
        cyc_reg  <= 16'h0000;
      end else if (lk_reg == RTC_LK_WAIT) begin
        cyc_reg  <= step_tick ? 16'h0000 : cyc_reg + 16'h0001;
        if (step_tick) step_reg <= step_reg - 8'h01;         // [R08]
      end
    end
  end

  assign SYNTH_LOCKED = lk_reg == RTC_LK_DONE;

  // ==========================================================================
  // assertion helpers
  // a 200-cycle repetition is too costly to unroll, so count instead
  logic [15:0] since_reg;
  logic        one_step_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      since_reg    <= 16'h0000;
      one_step_reg <= 1'b0;
    end else if (SYNTH_START) begin
      since_reg    <= 16'h0000;
      one_step_reg <= counted && lc_reg == 8'h01;
    end else if (since_reg != 16'hFFFF) begin
      since_reg    <= since_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // assertions
  sequence s_start_counted;
    SYNTH_START && counted && lc_reg == 8'h01;
  endsequence

  a_gated_write_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == RTC_ADDR_PWR_SAVE && !wr_gate
    |=> $stable(ps_reg)) // [R14]
    else $error("power-save changed without gate");
  a_ps_write_take: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ps |=> ps_reg == $past(REQ_WDATA)) // [R02]
    else $error("gated power-save write lost");
  a_cd_write_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
    req.wr && req.addr == RTC_ADDR_CD_OVR && !wr_gate
    |=> $stable(cd_reg)) // [R06]
    else $error("override changed without gate");
  a_cd_force: assert property (@(posedge CLK_SYS) disable iff (RST)
    cd_reg[RTC_BIT_CTRL] |-> CD_OUT) // [R05]
    else $error("override not forcing carrier detect");
  a_power_save_out: assert property (@(posedge CLK_SYS) disable iff (RST)
    wr_ps |=> POWER_SAVE == $past(REQ_WDATA[7])) // [R01]
    else $error("power-save output wrong");
  a_id_top_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    req.rd && req.addr == 6'h3F |=> RD_DATA[7:6] == 2'b00) // [R10]
    else $error("id top bits not zero");
  a_id_disabled: assert property (@(posedge CLK_SYS) disable iff (RST)
    req.rd && id_hit && !id_rd_en |=> RD_DATA == 8'h00) // [R15]
    else $error("id readable while disabled");
  a_id_lsb_low: assert property (@(posedge CLK_SYS) disable iff (RST)
    req.rd && req.addr == RTC_ADDR_ID_BASE && id_rd_en
    |=> RD_DATA == $past(CHIP_ID[7:0])) // [R11] [R13]
    else $error("id low byte wrong");
  a_lock_one_step: assert property (@(posedge CLK_SYS) disable iff (RST)
    one_step_reg && since_reg == 16'(RTC_LOCK_STEP_CYC)
    |-> SYNTH_LOCKED) // [R08]
    else $error("lock not after one 2 us step");
  a_lock_hold_wait: assert property (@(posedge CLK_SYS) disable iff (RST)
    one_step_reg && since_reg < 16'(RTC_LOCK_STEP_CYC)
    |-> !SYNTH_LOCKED) // [R08]
    else $error("lock reported before one 2 us step");
  a_lock_not_early: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_start_counted |=> !SYNTH_LOCKED [*8]) // [R08]
    else $error("lock reported early");
  a_lock_bypass: assert property (@(posedge CLK_SYS) disable iff (RST)
    SYNTH_START && !counted |=> SYNTH_LOCKED) // [R09]
    else $error("counted delay outside auto mode");

endmodule : rtc_regs

`default_nettype wire

// ### rtc_pkg.sv
// rtc_pkg: offsets, reset values, field positions and carrier types for the
// radio trim configuration register group.
// assumes a byte-wide register port on the system clock.
package rtc_pkg;

  // ==========================================================================
  // register offsets (byte addresses of the serial register port)
  localparam logic [5:0] RTC_ADDR_ANALOG    = 6'h20;
  localparam logic [5:0] RTC_ADDR_PWR_SAVE  = 6'h2E;
  localparam logic [5:0] RTC_ADDR_CD_OVR    = 6'h2F;
  localparam logic [5:0] RTC_ADDR_CLK_OVR   = 6'h32;
  localparam logic [5:0] RTC_ADDR_CLK_EN    = 6'h33;
  localparam logic [5:0] RTC_ADDR_LOCK_CNT  = 6'h38;
  localparam logic [5:0] RTC_ADDR_ID_BASE   = 6'h3C;

  // ==========================================================================
  // field positions
  localparam int RTC_BIT_CTRL       = 7;
  localparam int RTC_BIT_WR_GATE    = 6;
  localparam int RTC_BIT_ID_RD_EN   = 5;
  localparam int RTC_BIT_AUTO_SYNTH = 1;
  localparam int RTC_ID_WIDTH       = 30;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RTC_RST_PWR_SAVE = 8'h00;
  localparam logic [7:0] RTC_RST_CD_OVR   = 8'h00;
  localparam logic [7:0] RTC_RST_CLK_OVR  = 8'h00;
  localparam logic [7:0] RTC_RST_CLK_EN   = 8'h00;
  localparam logic [7:0] RTC_RST_LOCK_CNT = 8'h64;

  // ==========================================================================
  // timing: one lock-count step is 2 us at a 100 MHz system clock
  localparam int RTC_CLK_MHZ       = 100;
  localparam int RTC_LOCK_STEP_US  = 2;
  localparam int RTC_LOCK_STEP_CYC = RTC_LOCK_STEP_US * RTC_CLK_MHZ;

  // ==========================================================================
  // register access carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rtc_req_t;

  typedef enum logic [1:0] {
    RTC_LK_IDLE,
    RTC_LK_WAIT,
    RTC_LK_DONE
  } rtc_lock_state_t;

endpackage : rtc_pkg

// ### rtc_host.sv
// rtc_host: host model issuing one-byte accesses on the register port.
// assumes strobes are sampled on rising CLK_SYS, read answer a cycle later.
`timescale 1ns/1ps
`default_nettype none
module rtc_host
  import rtc_pkg::*;
(
  input  wire logic       CLK_SYS,
  output var  logic       REQ_WR,
  output var  logic       REQ_RD,
  output var  logic [5:0] REQ_ADDR,
  output var  logic [7:0] REQ_WDATA
);
  // ====================
  // access task
  initial begin
    REQ_WR = 1'b0;
    REQ_RD = 1'b0;
    REQ_ADDR = 6'h00;
    REQ_WDATA = 8'h00;
  end
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [7:0] d);
    @(negedge CLK_SYS);
    REQ_WR = w;
    REQ_RD = !w;
    REQ_ADDR = a;
    REQ_WDATA = d;
    @(negedge CLK_SYS);
    // released lines flip so a stale value is never trusted
    REQ_WR = 1'b0;
    REQ_RD = 1'b0;
    REQ_ADDR = ~a;
    REQ_WDATA = ~d;
  endtask : acc
endmodule : rtc_host
`default_nettype wire

// ### testbench.sv
// testbench: register group against an integer model of its contents.
// assumes rtc_regs and rtc_host; inputs change on falling CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rtc_pkg::*;
;
  logic                    clk_sys = 1'b0;
  logic                    rst, pll_lock_used, synth_start, cd_raw;
  logic [7:0]              analog_ctrl, radio_ctrl, d;
  logic [5:0]              a;
  logic [RTC_ID_WIDTH-1:0] chip_id;
  wire logic               req_wr, req_rd, rd_valid, power_save, cd_out;
  wire logic               synth_locked;
  wire logic [5:0]         req_addr;
  wire logic [7:0]         req_wdata, rd_data, clk_ovr, clk_en;
  int                      failures, checks_done, cycles, seed = 64;
  int                      mdl[64];
  rtc_host rtc_host_inst (.CLK_SYS(clk_sys), .REQ_WR(req_wr),
    .REQ_RD(req_rd), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata));
  rtc_regs rtc_regs_inst (.CLK_SYS(clk_sys), .RST(rst), .REQ_WR(req_wr),
    .REQ_RD(req_rd), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .ANALOG_CTRL(analog_ctrl), .RADIO_CTRL(radio_ctrl),
    .PLL_LOCK_USED(pll_lock_used), .SYNTH_START(synth_start),
    .CHIP_ID(chip_id), .CD_RAW(cd_raw), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .POWER_SAVE(power_save), .CD_OUT(cd_out),
    .CLK_OVR(clk_ovr), .CLK_EN(clk_en), .SYNTH_LOCKED(synth_locked));
  // ====================
  // clock, timeout, tasks
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] wa, input logic [7:0] wd);
    rtc_host_inst.acc(1'b1, wa, wd);
    if (wa inside {6'h32, 6'h33, 6'h38} || (wa inside {6'h2E, 6'h2F}
        && analog_ctrl[RTC_BIT_WR_GATE]))
      mdl[wa] = wd;
  endtask : wr
  task automatic rd(input logic [5:0] ra);
    logic [31:0] id;
    id = {2'b00, chip_id};
    rtc_host_inst.acc(1'b0, ra, 8'h00);
    chk(rd_valid, 1);
    if (ra >= 6'h3C)
      chk(rd_data, analog_ctrl[5] ? id[8*(ra-6'h3C) +: 8] : 0);
    else
      chk(rd_data, mdl[ra]);
  endtask : rd
  task automatic lock(input int exp);
    int k;
    k = 0;
    @(negedge clk_sys);
    synth_start = 1'b1;
    @(negedge clk_sys);
    synth_start = 1'b0;
    chk(synth_locked, exp == 0);
    while (synth_locked !== 1'b1 && k < 1000) begin
      @(negedge clk_sys);
      k++;
    end
    chk(k, exp);
  endtask : lock
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // ====================
  // main sequence
  initial begin
    {rst, pll_lock_used, synth_start, cd_raw} = 4'h8;
    analog_ctrl = 8'h00;
    radio_ctrl = 8'h00;
    chip_id = RTC_ID_WIDTH'($random(seed));
    foreach (mdl[i]) mdl[i] = 0;
    mdl[6'h38] = 8'h64;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 64; i++) rd(6'(i));
    chk({clk_ovr, clk_en, power_save, cd_out}, 0);
    wr(6'h2E, 8'h80);
    wr(6'h2F, 8'h80);
    chk({power_save, cd_out}, 0);
    analog_ctrl[RTC_BIT_WR_GATE] = 1'b1;
    wr(6'h2E, 8'h80);
    wr(6'h2F, 8'h80);
    wr(6'h32, 8'h41);
    wr(6'h33, 8'h41);
    chk({power_save, cd_out, clk_ovr, clk_en}, 18'h34141);
    repeat (60) begin
      a = 6'($random(seed));
      d = 8'($random(seed));
      analog_ctrl = 8'($random(seed)) & 8'h60;
      cd_raw = 1'($random(seed));
      chip_id = RTC_ID_WIDTH'($random(seed));
      if (a inside {6'h2E, 6'h2F}) d = d & 8'h80;
      wr(a, d);
      rd(a);
      chk({power_save, cd_out}, {mdl[46][7], mdl[47][7] | cd_raw});
    end
    analog_ctrl = 8'h20;
    for (int i = 60; i < 64; i++) rd(6'(i));
    analog_ctrl = 8'h00;
    wr(6'h38, 8'h01);
    lock(1 * RTC_LOCK_STEP_CYC);
    radio_ctrl[RTC_BIT_AUTO_SYNTH] = 1'b1;
    lock(0);
    radio_ctrl = 8'h00;
    pll_lock_used = 1'b1;
    lock(0);
    pll_lock_used = 1'b0;
    wr(6'h38, 8'h02);
    lock(2 * RTC_LOCK_STEP_CYC);
    results();
  end
endmodule : testbench
`default_nettype wire
